/* logic/tdm_output_tristate_control.v */
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`include "tdm_tristate_map.vh"
// Behaviour
// R1: Mode low: streams always driven, external tristate.
// R2: Mode high: device tristates streams per channel flag.
// R3: Drive-mode pin captured during reset pin low.
// R4: Enable priority: reset, drive pin, standby, flag.
// R5: Any disable: stream high or tristate, control low.
// R6: All enables high: stream and control carry data.
// R7: Control bit copies channel drive flag.
// R8: Two control lines, one bit per period.
// R9: Line 0 even streams, line 1 odd.
// R10: Stream 0 channel 0 ten periods early.
// R11: Streams 14/15 channel 0 three periods early.
// R12: Slower streams repeat bit per channel.
// R13: Repeats fall eight periods apart, same slot.
// R14: Periods numbered 1 to 2048, pairs in order.
// R15: External buffers tristate on low control bit.
// R16: Drive-mode pin synchronised before capture.

// ------------------------------------------------------------
// Synchronous FIFO with valid and ready on both sides.
// ------------------------------------------------------------
module tdm_sync_fifo #(
    parameter WIDTH = 13,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0] level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    wire push;
    wire pop;

    assign in_ready = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_ff];
    assign level = count_ff;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

// ------------------------------------------------------------
// Local output stream tristate control.
// ------------------------------------------------------------
module tdm_output_tristate_control #(
    parameter STREAMS = 16,
    parameter CHAN_BITS = 8
) (
    // Clock and reset
    input wire clock,
    input wire arst_n,
    // Avalon-MM slave
    input wire [4:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output wire [31:0] readdata,
    output wire waitrequest,
    // Device pins, asynchronous
    input wire reset_pin_n,
    input wire output_drive_pin,
    input wire local_output_drive_mode_pin,
    input wire ctrl_bit_clock_in,
    input wire frame_pulse_n,
    // Stream data from the switch core, same clock
    input wire [STREAMS-1:0] stream_data,
    input wire [STREAMS-1:0] local_chan_drive_flag,
    // Output streams and control lines
    output wire [STREAMS-1:0] local_serial_out,
    output wire [STREAMS-1:0] local_serial_out_oe,
    output wire [1:0] local_chan_tristate_ctrl
);
    localparam MEM_AW = CHAN_BITS + 4;
    localparam FW = MEM_AW + 1;

    reg [1:0] rst_sync_ff;
    reg [1:0] drv_sync_ff;
    reg [1:0] mode_sync_ff;
    reg [1:0] clk_sync_ff;
    reg [1:0] fp_sync_ff;
    reg clk_prev_ff;
    reg mode_ff;
    reg standby_ff;
    reg [31:0] rate_ff;
    reg [MEM_AW-1:0] mem_addr_ff;
    reg waitrequest_ff;
    reg [31:0] readdata_ff;
    reg [10:0] period_ff;
    reg [1:0] ctrl_ff;
    reg [STREAMS-1:0] out_ff;
    reg [STREAMS-1:0] oe_ff;
    reg flag_mem [0:(1<<MEM_AW)-1];
    reg [31:0] nxt_readdata;
    reg [10:0] nxt_period;
    reg [10:0] slot;
    reg [2:0] pair;
    reg [CHAN_BITS-1:0] ch_even;
    reg [CHAN_BITS-1:0] ch_odd;
    reg [1:0] rate_even;
    reg [1:0] rate_odd;
    wire tick;
    wire enable_all;
    wire [STREAMS-1:0] chan_active;
    wire fifo_in_ready;
    wire fifo_in_valid;
    wire fifo_out_valid;
    wire [FW-1:0] fifo_out_data;
    wire [4:0] fifo_level;
    wire req;

    // --------------------------------------------------------
    // Pin synchronisers.
    // --------------------------------------------------------
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= 2'h0;
            drv_sync_ff <= 2'h0;
            mode_sync_ff <= 2'h0;
            clk_sync_ff <= 2'h0;
            fp_sync_ff <= 2'h3;
            clk_prev_ff <= 1'b0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], reset_pin_n};
            drv_sync_ff <= {drv_sync_ff[0], output_drive_pin};
            mode_sync_ff <= {mode_sync_ff[0], local_output_drive_mode_pin}; // R16
            clk_sync_ff <= {clk_sync_ff[0], ctrl_bit_clock_in};
            fp_sync_ff <= {fp_sync_ff[0], frame_pulse_n};
            clk_prev_ff <= clk_sync_ff[1];
        end
    end

    assign tick = clk_sync_ff[1] & ~clk_prev_ff;

    // --------------------------------------------------------
    // Drive-mode capture while the reset pin is low.
    // --------------------------------------------------------
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= 1'b0;
        end else if (!rst_sync_ff[1]) begin
            mode_ff <= mode_sync_ff[1]; // R3
        end
    end

    // --------------------------------------------------------
    // Register bus.
    // --------------------------------------------------------
    assign req = (read | write) & waitrequest_ff;
    assign fifo_in_valid = req & write & (address == `OFS_MEM_DATA);

    always @* begin
        nxt_readdata = 32'h00000000;
        if (address == `OFS_CTRL) begin
            nxt_readdata[`CTRL_STANDBY_BIT] = standby_ff;
        end else if (address == `OFS_RATE) begin
            nxt_readdata = rate_ff;
        end else if (address == `OFS_MEM_ADDR) begin
            nxt_readdata[MEM_AW-1:0] = mem_addr_ff;
        end else if (address == `OFS_MEM_DATA) begin
            nxt_readdata[4:0] = fifo_level;
        end else if (address == `OFS_STATUS) begin
            nxt_readdata[`STATUS_MODE_BIT] = mode_ff;
            nxt_readdata[`STATUS_RSTPIN_BIT] = rst_sync_ff[1];
            nxt_readdata[`STATUS_DRIVE_BIT] = drv_sync_ff[1];
            nxt_readdata[`STATUS_PERIOD_LSB+10:`STATUS_PERIOD_LSB] = period_ff;
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            waitrequest_ff <= 1'b1;
            readdata_ff <= 32'h00000000;
            standby_ff <= `CTRL_RESET;
            rate_ff <= `RATE_RESET;
            mem_addr_ff <= {MEM_AW{1'b0}};
        end else begin
            waitrequest_ff <= 1'b1;
            if (req && !(fifo_in_valid && !fifo_in_ready)) begin
                waitrequest_ff <= 1'b0;
                readdata_ff <= read ? nxt_readdata : 32'h00000000;
                if (write) begin
                    if (address == `OFS_CTRL) begin
                        standby_ff <= writedata[`CTRL_STANDBY_BIT];
                    end else if (address == `OFS_RATE) begin
                        rate_ff <= writedata;
                    end else if (address == `OFS_MEM_ADDR) begin
                        mem_addr_ff <= writedata[MEM_AW-1:0];
                    end else if (address == `OFS_MEM_DATA) begin
                        mem_addr_ff <= mem_addr_ff + 1'b1;
                    end
                end
            end
        end
    end

    // --------------------------------------------------------
    // Connection-memory write buffer; drains between link ticks.
    // --------------------------------------------------------
    tdm_sync_fifo #(
        .WIDTH(FW),
        .DEPTH(`FIFO_DEPTH),
        .AW(4)
    ) u_wr_fifo (
        .clock(clock),
        .arst_n(arst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({mem_addr_ff, writedata[0]}),
        .out_valid(fifo_out_valid),
        .out_ready(~tick),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    always @(posedge clock) begin
        if (fifo_out_valid && !tick) begin
            flag_mem[fifo_out_data[FW-1:1]] <= fifo_out_data[0];
        end
    end

    // --------------------------------------------------------
    // Control-line slot sequencing.
    // --------------------------------------------------------
    always @* begin
        if (!fp_sync_ff[1] || period_ff == `PERIODS_PER_FRAME) begin
            nxt_period = `FIRST_PERIOD; // R14
        end else begin
            nxt_period = period_ff + 11'h001;
        end
        slot = nxt_period + `SLOT_ADVANCE; // R10 R11
        pair = slot[2:0]; // R9 R13
        rate_even = rate_ff[{pair, 2'h0} +: 2];
        rate_odd = rate_ff[{pair, 2'h2} +: 2];
        ch_even = slot[10:3] >> rate_even; // R12
        ch_odd = slot[10:3] >> rate_odd; // R12
    end

    assign enable_all = rst_sync_ff[1] & drv_sync_ff[1] & standby_ff; // R4

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            period_ff <= `PERIODS_PER_FRAME;
            ctrl_ff <= 2'h0;
        end else if (tick) begin
            period_ff <= nxt_period;
            ctrl_ff[0] <= enable_all & flag_mem[{pair, 1'b0, ch_even}]; // R7 R8 R5
            ctrl_ff[1] <= enable_all & flag_mem[{pair, 1'b1, ch_odd}]; // R7 R8 R5
        end else if (!enable_all) begin
            ctrl_ff <= 2'h0; // R5
        end
    end

    // --------------------------------------------------------
    // Output stream drive.
    // --------------------------------------------------------
    assign chan_active = {STREAMS{enable_all}} & local_chan_drive_flag; // R4 R6

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            out_ff <= {STREAMS{1'b1}};
            oe_ff <= {STREAMS{1'b0}};
        end else if (mode_ff) begin
            out_ff <= stream_data;
            oe_ff <= chan_active; // R2 R5 R6
        end else begin
            out_ff <= (stream_data & chan_active) | ~chan_active; // R1 R5 R6
            oe_ff <= {STREAMS{1'b1}}; // R1
        end
    end

    assign readdata = readdata_ff;
    assign waitrequest = waitrequest_ff;
    assign local_serial_out = out_ff;
    assign local_serial_out_oe = oe_ff;
    assign local_chan_tristate_ctrl = ctrl_ff; // R15
endmodule

/* logic/tdm_tristate_map.vh */
`ifndef TDM_TRISTATE_MAP_VH
`define TDM_TRISTATE_MAP_VH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_CTRL 5'h00
`define OFS_RATE 5'h04
`define OFS_MEM_ADDR 5'h08
`define OFS_MEM_DATA 5'h0C
`define OFS_STATUS 5'h10
// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define CTRL_STANDBY_BIT 0
`define CTRL_RESET 1'h0
`define RATE_RESET 32'h00000000
`define STATUS_MODE_BIT 0
`define STATUS_RSTPIN_BIT 1
`define STATUS_DRIVE_BIT 2
`define STATUS_PERIOD_LSB 16
// ------------------------------------------------------------
// Frame timing in control-clock periods; write FIFO depth in entries
// ------------------------------------------------------------
`define PERIODS_PER_FRAME 11'h000
`define FIRST_PERIOD 11'h001
`define SLOT_ADVANCE 11'h009
`define FIFO_DEPTH 16
`endif

/* testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    reg clock = 1'h0, arst_n = 1'h0, read = 1'h0, write = 1'h0, reset_pin_n = 1'h0;
    reg output_drive_pin = 1'h0, local_output_drive_mode_pin = 1'h1;
    reg ctrl_bit_clock_in = 1'h0, frame_pulse_n = 1'h1;
    reg [4:0] address = 5'h00;
    reg [31:0] writedata = 32'h0, rd;
    reg [15:0] stream_data = 16'h0, local_chan_drive_flag = 16'h0;
    wire [31:0] readdata;
    wire waitrequest;
    wire [15:0] local_serial_out, local_serial_out_oe, line;
    wire [1:0] local_chan_tristate_ctrl;
    integer err_count = 0, samples_checked = 0, cyc = 0, lk = 0, i;
    tdm_output_tristate_control uut (
        .clock(clock),
        .arst_n(arst_n),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .reset_pin_n(reset_pin_n),
        .output_drive_pin(output_drive_pin),
        .local_output_drive_mode_pin(local_output_drive_mode_pin),
        .ctrl_bit_clock_in(ctrl_bit_clock_in),
        .frame_pulse_n(frame_pulse_n),
        .stream_data(stream_data),
        .local_chan_drive_flag(local_chan_drive_flag),
        .local_serial_out(local_serial_out),
        .local_serial_out_oe(local_serial_out_oe),
        .local_chan_tristate_ctrl(local_chan_tristate_ctrl)
    );
    tdm_bufs partner (
        .ctrl_bit_clock_in(ctrl_bit_clock_in),
        .frame_pulse_n(frame_pulse_n),
        .local_serial_out(local_serial_out),
        .local_chan_tristate_ctrl(local_chan_tristate_ctrl),
        .line(line)
    );
    initial forever #20 clock = ~clock;
    initial begin
        #7;
        forever #160 ctrl_bit_clock_in = ~ctrl_bit_clock_in;
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
            end
        end
    endtask
    task bus(input wr, input [4:0] a, input [31:0] d);
        begin
            @(posedge clock);
            address <= a;
            read <= !wr;
            write <= wr;
            writedata <= d;
            @(posedge clock);
            while (waitrequest !== 1'h0) @(posedge clock);
            rd = readdata;
            read <= 1'h0;
            write <= 1'h0;
        end
    endtask
    task stream_run(input m);
        repeat (20) begin
            @(posedge clock);
            stream_data <= $urandom;
            local_chan_drive_flag <= $urandom;
            repeat (5) @(posedge clock);
            check(local_serial_out, m ? stream_data : 16'(stream_data | ~local_chan_drive_flag));
            check(local_serial_out_oe, m ? local_chan_drive_flag : 16'hFFFF);
        end
    endtask
    task results;
        begin
            $display("checks %0d, mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    function [1:0] exp_ctrl(input integer n);
        integer p;
        begin
            p = n % 2048 + 1;
            exp_ctrl[0] = p == 2039 || p == 2042 || p == 2 || p == 9 || p == 10 || p == 17
                || p == 18 || (p % 8 == 0 && (p > 2039 || p < 49));
            exp_ctrl[1] = p == 2046 || p == 2040;
        end
    endfunction
    always @(posedge ctrl_bit_clock_in) begin
        if (lk >= 4096) begin
            check(local_chan_tristate_ctrl, exp_ctrl(lk));
        end
        lk = lk + 1;
    end
    always @(negedge ctrl_bit_clock_in) begin
        frame_pulse_n <= lk % 2048 != 2047;
    end
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            err_count = err_count + 1;
            results;
        end
    end
    initial begin
        rd = $urandom(32'hDF6C6F4A);
        repeat (5) @(posedge clock);
        arst_n <= 1'h1;
        bus(0, 5'h00, 0);
        check(rd, 0);
        bus(0, 5'h04, 0);
        check(rd, 0);
        bus(0, 5'h14, 0);
        check(rd, 0);
        reset_pin_n <= 1'h1;
        repeat (5) @(posedge clock);
        local_output_drive_mode_pin <= 1'h0;
        bus(0, 5'h10, 0);
        check(rd[2:0], 3'h3);
        check(local_serial_out_oe, 0);
        bus(1, 5'h00, 1);
        output_drive_pin <= 1'h1;
        stream_run(1);
        reset_pin_n <= 1'h0;
        repeat (6) @(posedge clock);
        check({local_serial_out, local_serial_out_oe}, 32'hFFFFFFFF);
        reset_pin_n <= 1'h1;
        repeat (5) @(posedge clock);
        stream_run(0);
        local_chan_drive_flag <= 16'hFFFF;
        bus(1, 5'h04, 32'h2130);
        bus(0, 5'h04, 0);
        check(rd, 32'h2130);
        bus(1, 5'h08, 0);
        for (i = 0; i < 4096; i = i + 1) begin
            bus(1, 5'h0C, i == 0 || i == 12'h200 || i == 12'h300 || i == 12'h401
                || i == 12'h600 || i == 12'hF00);
        end
        wait (lk == 6200);
        results;
    end
endmodule

/* testbench/tdm_bufs.sv */
`timescale 1ns/1ns
module tdm_bufs (
    // Link timing
    input wire ctrl_bit_clock_in,
    input wire frame_pulse_n,
    // Device side and lines
    input wire [15:0] local_serial_out,
    input wire [1:0] local_chan_tristate_ctrl,
    output wire [15:0] line
);
    reg [2:0] pair_ff = 3'h0;
    reg [15:0] en_ff = 16'h0000;
    genvar s;
    always @(posedge ctrl_bit_clock_in) begin
        en_ff[{pair_ff, 1'h0}] <= local_chan_tristate_ctrl[0];
        en_ff[{pair_ff, 1'h1}] <= local_chan_tristate_ctrl[1];
        pair_ff <= frame_pulse_n ? pair_ff + 3'h1 : 3'h2;
    end
    for (s = 0; s < 16; s = s + 1) begin : g_line
        assign line[s] = en_ff[s] ? local_serial_out[s] : 1'hz;
    end
endmodule

/* testbench/tdm_props.sv */
`timescale 1ns/1ns
module tdm_props #(
    parameter STREAMS = 16
) (
    // Clock, reset and bus
    input wire clock,
    input wire arst_n,
    input wire [4:0] address,
    input wire read,
    input wire write,
    input wire waitrequest,
    // Pins and streams
    input wire reset_pin_n,
    input wire output_drive_pin,
    input wire ctrl_bit_clock_in,
    input wire [STREAMS-1:0] stream_data,
    input wire [STREAMS-1:0] local_chan_drive_flag,
    input wire [STREAMS-1:0] local_serial_out,
    input wire [STREAMS-1:0] local_serial_out_oe,
    input wire [1:0] local_chan_tristate_ctrl
);
    // ----
    // Cycles since the last link clock rise.
    // ----
    reg lk_ff;
    reg [3:0] age_ff;
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lk_ff <= 1'h0;
            age_ff <= 4'hF;
        end else begin
            lk_ff <= ctrl_bit_clock_in;
            age_ff <= (ctrl_bit_clock_in && !lk_ff) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hF};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_wait_pulse: assert property ($fell(waitrequest) |=> waitrequest)
        else $error("wait low too long");
    a_wait_answer: assert property ((read || write) && waitrequest && address != 5'h0C
        |=> !waitrequest) else $error("no answer");
    a_pin_ctrl: assert property (!reset_pin_n [*5] |-> local_chan_tristate_ctrl == 2'h0)
        else $error("ctrl live in reset");
    a_drive_ctrl: assert property (!output_drive_pin [*5] |-> local_chan_tristate_ctrl == 2'h0)
        else $error("ctrl live undriven");
    a_flag_out: assert property ($past(arst_n) && $past(local_chan_drive_flag) == '0
        |-> &local_serial_out || local_serial_out_oe == '0) else $error("flag off active");
    a_mode_data: assert property ($past(arst_n) && local_serial_out_oe != '1
        |-> local_serial_out == $past(stream_data)) else $error("tristate mode data");
    a_mode_high: assert property ($past(arst_n) && local_serial_out_oe == '1
        |-> (~local_serial_out & $past(stream_data)) == '0) else $error("driven low");
    a_ctrl_tick: assert property ($changed(local_chan_tristate_ctrl) &&
        local_chan_tristate_ctrl != 2'h0 && $past(local_chan_tristate_ctrl) != 2'h0
        |-> age_ff >= 4'h1 && age_ff <= 4'h6) else $error("ctrl off tick");
endmodule
bind tdm_output_tristate_control tdm_props #(.STREAMS(STREAMS)) u_props (
    .clock(clock),
    .arst_n(arst_n),
    .address(address),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .reset_pin_n(reset_pin_n),
    .output_drive_pin(output_drive_pin),
    .ctrl_bit_clock_in(ctrl_bit_clock_in),
    .stream_data(stream_data),
    .local_chan_drive_flag(local_chan_drive_flag),
    .local_serial_out(local_serial_out),
    .local_serial_out_oe(local_serial_out_oe),
    .local_chan_tristate_ctrl(local_chan_tristate_ctrl)
);
